// ===== core/ten_gig_mac_frame_tx_path.sv
// Purpose: frame formatting of a 10G MAC: transmit serialiser and receive filter
// Assumes: all inputs on clk_i; receive frames arrive DA..FCS with a spare cycle between frames
// Notes:   transmit side emits one byte slot per cycle with a control flag
`timescale 1ns/1ps
`include "mac_cfg.svh"
module ten_gig_mac_frame_tx_path (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          tx_stream_rst_n_i,
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic      [31:0]   wb_dat_o,
  output logic               wb_ack_o,
  input  wire mac_pkg::beat_t tx_beat_i,
  input  wire logic          tx_valid_i,
  output logic               tx_ready_o,
  output logic      [7:0]    txd_o,
  output logic               txc_o,
  input  wire mac_pkg::beat_t rx_beat_i,
  input  wire logic          rx_valid_i,
  output mac_pkg::beat_t     rx_beat_o,
  output logic               rx_valid_o,
  output logic               rx_bad_o
);
  // one byte step of the reflected ethernet crc
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ (`CRC_POLY & {32{r[0] ^ b[i]}});
    end
    return r;
  endfunction

  // highest lane whose keep bit is set
  function automatic logic [2:0] top_lane(input logic [7:0] k);
    logic [2:0] t;
    t = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (k[i]) t = 3'(i);
    end
    return t;
  endfunction

  // ---------------- register bus ----------------
  logic [15:0] cfg_reg, cfg_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        ack_reg, ack_next;
  logic [15:0] lt_reg, lt_next;
  logic [15:0] good_reg, good_next, bad_reg, bad_next;
  logic        is_type, is_vlan, is_pause;

  assign is_type  = lt_reg >= `LT_TYPE_MIN;
  assign is_vlan  = lt_reg == `LT_VLAN;
  assign is_pause = lt_reg == `LT_PAUSE;

  // single-wait-state slave: ack one cycle after the request, dropped the next
  always_comb begin
    ack_next  = wb_cyc_i & wb_stb_i & ~ack_reg;
    cfg_next  = cfg_reg;
    rdat_next = rdat_reg;
    if (ack_next) begin
      case (wb_adr_i)
        `REG_CONFIG: begin
          if (wb_we_i && wb_sel_i[0]) cfg_next[7:0] = wb_dat_i[7:0] & 8'(`CFG_WMASK);
          if (wb_we_i && wb_sel_i[1]) cfg_next[15:8] = wb_dat_i[15:8];
          rdat_next = {16'h0000, cfg_reg};
        end
        `REG_TX_STATUS: rdat_next = {13'h0000, is_pause, is_vlan, is_type, lt_reg};
        `REG_RX_STATUS: rdat_next = {bad_reg, good_reg};
        default:        rdat_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_reg  <= `CFG_RESET;
      rdat_reg <= 32'h0000_0000;
      ack_reg  <= 1'b0;
    end else begin
      cfg_reg  <= cfg_next;
      rdat_reg <= rdat_next;
      ack_reg  <= ack_next;
    end
  end
  assign wb_dat_o = rdat_reg;
  assign wb_ack_o = ack_reg;

  logic       fcs_pass, gap_avg, ifg_adj, len_chk;
  logic [9:0] min_gap;
  assign fcs_pass = cfg_reg[`CFG_FCS_PASS];
  assign gap_avg  = cfg_reg[`CFG_GAP_AVG];
  assign ifg_adj  = cfg_reg[`CFG_IFG_ADJ];
  assign len_chk  = cfg_reg[`CFG_LEN_CHK];
  // adjustment only lengthens the gap, never below the 12-byte floor
  assign min_gap = (ifg_adj && {cfg_reg[15:8], 2'b00} > 10'(`IFG_BYTES)) ?
                   {cfg_reg[15:8], 2'b00} : 10'(`IFG_BYTES);

  // ---------------- transmit ----------------
  mac_pkg::tx_state_t st_reg, st_next;
  mac_pkg::beat_t cur_reg, cur_next, nxt_reg, nxt_next;
  logic        cur_v_reg, cur_v_next, nxt_v_reg, nxt_v_next;
  logic [2:0]  lane_reg, lane_next, pre_reg, pre_next;
  logic [1:0]  col_reg, col_next, fidx_reg, fidx_next, dic_reg, dic_next;
  logic [15:0] bcnt_reg, bcnt_next;
  logic [9:0]  gap_reg, gap_next;
  logic [31:0] crc_reg, crc_next;
  logic [7:0]  txd_reg, txd_next;
  logic        txc_reg, txc_next, rdy_reg, rdy_next, take, consume;
  logic [7:0]  byte_now;

  assign take     = tx_valid_i & rdy_reg;
  assign byte_now = cur_reg.data[{lane_reg, 3'b000} +: 8];

  always_comb begin
    st_next = st_reg;   lane_next = lane_reg; pre_next = pre_reg;
    fidx_next = fidx_reg; dic_next = dic_reg; bcnt_next = bcnt_reg;
    crc_next = crc_reg; lt_next = lt_reg;     consume = 1'b0;
    txd_next = `XG_IDLE; txc_next = 1'b1;
    col_next = col_reg + 2'd1; // lane of the slot being produced
    gap_next = (gap_reg == 10'h3ff) ? gap_reg : gap_reg + 10'd1;
    case (st_reg)
      mac_pkg::TX_IDLE: begin
        // start only on a 4-byte boundary once the gap allows it
        if (cur_v_reg && col_reg == 2'd3 &&
            (gap_reg >= min_gap || (gap_avg && gap_reg + 10'd3 - 10'(dic_reg) >= min_gap))) begin
          txd_next = `XG_START;
          st_next  = mac_pkg::TX_PRE;
          pre_next = 3'd0;
          crc_next = 32'hffff_ffff;
          bcnt_next = 16'h0000;
          lane_next = 3'd0;
          gap_next = 10'd0;
          if (!gap_avg) dic_next = 2'd0;
          else if (gap_reg < min_gap) dic_next = dic_reg + 2'(min_gap - gap_reg);
          else if (gap_reg - min_gap >= 10'(dic_reg)) dic_next = 2'd0;
          else dic_next = dic_reg - 2'(gap_reg - min_gap);
        end
      end
      mac_pkg::TX_PRE: begin
        txc_next = 1'b0;
        txd_next = (pre_reg == 3'd6) ? `XG_SFD : `XG_PRE;
        pre_next = pre_reg + 3'd1;
        if (pre_reg == 3'd6) st_next = mac_pkg::TX_DATA;
      end
      mac_pkg::TX_DATA: begin
        if (!cur_v_reg) begin
          // client starved mid-frame: mark the frame errored and close it
          txd_next = `XG_ERROR;
          st_next  = mac_pkg::TX_TERM;
        end else begin
          txc_next  = 1'b0;
          txd_next  = byte_now;
          crc_next  = crc_byte(crc_reg, byte_now);
          bcnt_next = bcnt_reg + 16'd1;
          if (bcnt_reg == 16'd12) lt_next[15:8] = byte_now;
          if (bcnt_reg == 16'd13) lt_next[7:0] = byte_now;
          lane_next = lane_reg + 3'd1;
          if (lane_reg == top_lane(cur_reg.keep)) begin
            consume   = 1'b1;
            lane_next = 3'd0;
            if (cur_reg.last) begin
              fidx_next = 2'd0;
              if (fcs_pass) st_next = mac_pkg::TX_TERM;
              else if (bcnt_next < `MIN_NO_FCS) st_next = mac_pkg::TX_PAD;
              else st_next = mac_pkg::TX_FCS;
            end
          end
        end
      end
      mac_pkg::TX_PAD: begin
        txc_next  = 1'b0;
        txd_next  = 8'h00;
        crc_next  = crc_byte(crc_reg, 8'h00);
        bcnt_next = bcnt_reg + 16'd1;
        if (bcnt_next == `MIN_NO_FCS) st_next = mac_pkg::TX_FCS;
      end
      mac_pkg::TX_FCS: begin
        // low register byte leaves first, its bit 0 carrying the x31 term
        txc_next  = 1'b0;
        txd_next  = ~crc_reg[{fidx_reg, 3'b000} +: 8];
        fidx_next = fidx_reg + 2'd1;
        if (fidx_reg == 2'd3) st_next = mac_pkg::TX_TERM;
      end
      mac_pkg::TX_TERM: begin
        txd_next = `XG_TERM;
        gap_next = 10'd1; // terminate byte counts toward the gap
        st_next  = mac_pkg::TX_IDLE;
      end
      default: st_next = mac_pkg::TX_IDLE;
    endcase
    // two-deep holding so the serialiser never waits on the ready round trip
    cur_next = cur_reg; cur_v_next = cur_v_reg & ~consume;
    nxt_next = nxt_reg; nxt_v_next = nxt_v_reg;
    if (!cur_v_next && nxt_v_next) begin
      cur_next = nxt_reg; cur_v_next = 1'b1; nxt_v_next = 1'b0;
    end
    if (take) begin
      if (!cur_v_next) begin
        cur_next = tx_beat_i; cur_v_next = 1'b1;
      end else begin
        nxt_next = tx_beat_i; nxt_v_next = 1'b1;
      end
    end
    rdy_next = ~nxt_v_next;
    // a start picked in this very cycle is cancelled too, so no lone start code leaks out
    if (!tx_stream_rst_n_i) begin
      cur_v_next = 1'b0;
      nxt_v_next = 1'b0;
      rdy_next   = 1'b0;
      st_next    = mac_pkg::TX_IDLE;
      txc_next   = 1'b1;
      txd_next   = `XG_IDLE;
      if (st_reg != mac_pkg::TX_IDLE) begin
        txd_next = `XG_ERROR;
        gap_next = 10'd1; // the cut frame still earns a full gap
      end
    end
  end

  // transmit registers; gap starts full so the first frame need not wait
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg    <= mac_pkg::TX_IDLE;
      cur_v_reg <= 1'b0;
      nxt_v_reg <= 1'b0;
      cur_reg   <= '0;
      nxt_reg   <= '0;
      lane_reg  <= 3'd0;
      pre_reg   <= 3'd0;
      col_reg   <= 2'd0;
      fidx_reg  <= 2'd0;
      dic_reg   <= 2'd0;
      bcnt_reg  <= 16'h0000;
      gap_reg   <= 10'(`IFG_BYTES);
      crc_reg   <= 32'hffff_ffff;
      lt_reg    <= 16'h0000;
      txd_reg   <= `XG_IDLE;
      txc_reg   <= 1'b1;
      rdy_reg   <= 1'b0;
    end else begin
      st_reg    <= st_next;
      cur_v_reg <= cur_v_next;
      nxt_v_reg <= nxt_v_next;
      cur_reg   <= cur_next;
      nxt_reg   <= nxt_next;
      lane_reg  <= lane_next;
      pre_reg   <= pre_next;
      col_reg   <= col_next;
      fidx_reg  <= fidx_next;
      dic_reg   <= dic_next;
      bcnt_reg  <= bcnt_next;
      gap_reg   <= gap_next;
      crc_reg   <= crc_next;
      lt_reg    <= lt_next;
      txd_reg   <= txd_next;
      txc_reg   <= txc_next;
      rdy_reg   <= rdy_next;
    end
  end
  assign txd_o = txd_reg;
  assign txc_o = txc_reg;
  assign tx_ready_o = rdy_reg;

  // ---------------- receive ----------------
  mac_pkg::beat_t hold_reg, hold_next, out_reg, out_next;
  logic        hold_v_reg, hold_v_next, tail_reg, tail_next, ov_reg, ov_next, bad_o_reg, bad_o_next;
  logic        bad_t_reg, bad_t_next, is_len_reg, is_len_next;
  logic [12:0] idx_reg, idx_next, hidx_reg, hidx_next;
  logic [15:0] len_reg, len_next, lim_reg, lim_next, lim_len, lim, total;
  logic [31:0] rcrc_reg, rcrc_next, rcrc_all;
  logic [7:0]  in_mask, hold_mask;
  logic [3:0]  in_cnt;
  logic        len_err;

  always_comb begin
    len_next = len_reg; is_len_next = is_len_reg;
    if (rx_valid_i && idx_reg == 13'd1) begin
      len_next    = {rx_beat_i.data[39:32], rx_beat_i.data[47:40]};
      is_len_next = len_next < `LT_TYPE_MIN;
    end
    // pad is cut only for short length frames without fcs passing
    lim_len = (is_len_next && len_next < `MIN_DATA_PAD && !fcs_pass) ?
              `HDR_BYTES + len_next : 16'hffff;
    in_cnt = 4'd0;
    rcrc_all = rcrc_reg;
    for (int i = 0; i < 8; i++) begin
      if (rx_beat_i.keep[i]) begin
        in_cnt = in_cnt + 4'd1;
        rcrc_all = crc_byte(rcrc_all, rx_beat_i.data[8*i +: 8]);
      end
    end
    total = {idx_reg, 3'b000} + 16'(in_cnt);
    lim = lim_len;
    if (rx_beat_i.last && !fcs_pass && total - 16'd4 < lim) lim = total - 16'd4;
    if (tail_reg) lim = lim_reg;
    for (int i = 0; i < 8; i++) begin
      in_mask[i]   = rx_beat_i.keep[i] && ({idx_reg, 3'b000} + 16'(i)) < lim;
      hold_mask[i] = hold_reg.keep[i] && ({hidx_reg, 3'b000} + 16'(i)) < lim;
    end
    len_err = len_chk && is_len_next && (len_next >= `MIN_DATA_PAD ?
              len_next != total - `OVERHEAD_BYTES : total != `MIN_FRAME);
    hold_next = hold_reg; hold_v_next = hold_v_reg; hidx_next = hidx_reg;
    idx_next = idx_reg; rcrc_next = rcrc_reg; tail_next = 1'b0; lim_next = lim_reg;
    bad_t_next = bad_t_reg; out_next = out_reg; ov_next = 1'b0; bad_o_next = 1'b0;
    good_next = good_reg; bad_next = bad_reg;
    if (tail_reg) begin
      // final beat of a frame whose last input beat still held bytes to deliver
      out_next = '{data: hold_reg.data, keep: hold_mask, last: 1'b1};
      ov_next = 1'b1; bad_o_next = bad_t_reg; hold_v_next = 1'b0;
    end else if (rx_valid_i) begin
      rcrc_next = rcrc_all; idx_next = idx_reg + 13'd1;
      if (rx_beat_i.last) begin
        bad_t_next = (rcrc_all != `CRC_RESIDUE) || len_err;
        if (bad_t_next) bad_next = bad_reg + 16'd1;
        else good_next = good_reg + 16'd1;
        idx_next = 13'd0; rcrc_next = 32'hffff_ffff;
        if (in_mask == 8'h00) begin
          out_next = '{data: hold_reg.data, keep: hold_mask, last: 1'b1};
          ov_next = hold_v_reg; bad_o_next = bad_t_next; hold_v_next = 1'b0;
        end else begin
          out_next = '{data: hold_reg.data, keep: hold_mask, last: 1'b0};
          ov_next = hold_v_reg; tail_next = 1'b1; lim_next = lim;
          hold_next = rx_beat_i; hidx_next = idx_reg; hold_v_next = 1'b1;
        end
      end else if (in_mask != 8'h00) begin
        out_next = '{data: hold_reg.data, keep: hold_mask, last: 1'b0};
        ov_next = hold_v_reg;
        hold_next = rx_beat_i; hidx_next = idx_reg; hold_v_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hold_reg <= '0; out_reg <= '0; hold_v_reg <= 1'b0; tail_reg <= 1'b0; ov_reg <= 1'b0;
      bad_o_reg <= 1'b0; bad_t_reg <= 1'b0; is_len_reg <= 1'b0; idx_reg <= 13'd0;
      hidx_reg <= 13'd0; len_reg <= 16'h0000; lim_reg <= 16'hffff;
      rcrc_reg <= 32'hffff_ffff; good_reg <= 16'h0000; bad_reg <= 16'h0000;
    end else begin
      hold_reg <= hold_next; out_reg <= out_next; hold_v_reg <= hold_v_next;
      tail_reg <= tail_next; ov_reg <= ov_next; bad_o_reg <= bad_o_next;
      bad_t_reg <= bad_t_next; is_len_reg <= is_len_next; idx_reg <= idx_next;
      hidx_reg <= hidx_next; len_reg <= len_next; lim_reg <= lim_next;
      rcrc_reg <= rcrc_next; good_reg <= good_next; bad_reg <= bad_next;
    end
  end
  assign rx_beat_o  = out_reg;
  assign rx_valid_o = ov_reg;
  assign rx_bad_o   = bad_o_reg;
endmodule

// ===== core/mac_cfg.svh
// Purpose: constants for the 10G MAC frame path (offsets, fields, codes, timing)
// Assumes: included by bare name from the top module, the monitor and the test
// Notes:   byte addresses on a 32-bit classic Wishbone
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH
`define REG_CONFIG     8'h00
`define REG_TX_STATUS  8'h04
`define REG_RX_STATUS  8'h08
`define CFG_RESET      16'h0000
`define CFG_WMASK      16'hff0f
`define CFG_FCS_PASS   0
`define CFG_GAP_AVG    1
`define CFG_IFG_ADJ    2
`define CFG_LEN_CHK    3
`define LT_TYPE_MIN    16'h0600
`define LT_VLAN        16'h8100
`define LT_PAUSE       16'h8808
`define MIN_DATA_PAD   16'h002e
`define HDR_BYTES      16'h000e
`define OVERHEAD_BYTES 16'h0012
`define MIN_FRAME      16'h0040
`define MIN_NO_FCS     16'h003c
`define IFG_BITS       96
`define IFG_BYTES      (`IFG_BITS / 8)
`define CRC_POLY       32'hedb88320
`define CRC_RESIDUE    32'hdebb20e3
`define XG_IDLE        8'h07
`define XG_START       8'hfb
`define XG_TERM        8'hfd
`define XG_ERROR       8'hfe
`define XG_PRE         8'h55
`define XG_SFD         8'hd5
`endif

// ===== core/mac_pkg.sv
// Purpose: types shared by the MAC frame path
// Assumes: constants live in mac_cfg.svh
// Notes:   beat_t carries one 64-bit stream beat
package mac_pkg;
  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  keep;
    logic        last;
  } beat_t;
  // gray codes along idle -> preamble -> data -> pad -> fcs -> terminate
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_PRE  = 3'b001,
    TX_DATA = 3'b011,
    TX_PAD  = 3'b010,
    TX_FCS  = 3'b110,
    TX_TERM = 3'b111
  } tx_state_t;
endpackage

// ===== testbench/mac_tx_client.sv
// Purpose: client logic feeding the transmit stream, one frame per call
// Assumes: send is called just after a rising clk_i edge
// Notes:   released lanes show the inverse of the last value, never stale data
`timescale 1ns/1ps
module mac_tx_client (
  input  wire logic      clk_i,
  input  wire logic      tx_ready_i,
  output mac_pkg::beat_t beat_o,
  output logic           valid_o
);
  initial begin
    beat_o  = 73'h0;
    valid_o = 1'b0;
  end
  // hold each beat until ready is sampled high; hold keeps valid up for back-to-back
  task automatic send(input logic [7:0] fr[$], input int gap, input logic hold);
    int n;
    int i;
    repeat (gap) @(posedge clk_i);
    for (n = 0; n < fr.size(); n += 8) begin
      valid_o <= 1'b1;
      for (i = 0; i < 8; i++) begin
        beat_o.data[8*i +: 8] <= (n + i < fr.size()) ? fr[n + i] : ~fr[fr.size() - 1];
        beat_o.keep[i]        <= n + i < fr.size();
      end
      beat_o.last <= n + 8 >= fr.size();
      do @(posedge clk_i); while (tx_ready_i !== 1'b1);
    end
    if (!hold) begin
      valid_o     <= 1'b0;
      beat_o.data <= ~beat_o.data;
    end
  endtask
  // abandon a frame after the bench cut the transfer short
  task automatic drop();
    valid_o <= 1'b0;
  endtask
endmodule

// ===== testbench/ten_gig_mac_frame_tx_path_monitor.sv
// Purpose: concurrent checks on the bus, transmit byte stream and receive flags
// Assumes: one clock domain, rst_i synchronous active high
// Notes:   start alignment is judged against the phase of the first start seen since rst_i or a stream reset
`timescale 1ns/1ps
`include "mac_cfg.svh"
module ten_gig_mac_frame_tx_path_monitor (
  input wire logic           clk_i,
  input wire logic           rst_i,
  input wire logic           tx_stream_rst_n_i,
  input wire logic           wb_cyc_i,
  input wire logic           wb_stb_i,
  input wire logic           wb_ack_o,
  input wire logic           tx_ready_o,
  input wire logic [7:0]     txd_o,
  input wire logic           txc_o,
  input wire mac_pkg::beat_t rx_beat_o,
  input wire logic           rx_valid_o,
  input wire logic           rx_bad_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       start_w;
  logic [1:0] slot_reg;
  logic [1:0] slot_next;
  logic [2:0] phase_reg;
  logic [2:0] phase_next;
  assign start_w = txc_o && txd_o == `XG_START;
  // slot phase relearnt after a stream reset; the column count restarts only on rst_i
  always_comb begin
    slot_next  = slot_reg + 2'h1;
    phase_next = phase_reg;
    if (start_w && !phase_reg[2]) phase_next = {1'b1, slot_reg};
    if (rst_i || !tx_stream_rst_n_i) phase_next = 3'h0;
    if (rst_i) slot_next = 2'h0;
  end
  // registers only
  always_ff @(posedge clk_i) begin
    slot_reg  <= slot_next;
    phase_reg <= phase_next;
  end
  sequence pre_s; (!txc_o && txd_o == `XG_PRE) [*6]; endsequence
  sequence sfd_s; !txc_o && txd_o == `XG_SFD; endsequence
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_start_preamble: assert property (disable iff (rst_i || !tx_stream_rst_n_i)
    start_w |=> pre_s ##1 sfd_s) else $error("preamble after start wrong");
  a_start_aligned: assert property (start_w && phase_reg[2] |-> slot_reg == phase_reg[1:0])
    else $error("start off the 4-byte column");
  a_gap_floor: assert property (txc_o && txd_o == `XG_TERM |=> !start_w [*8])
    else $error("gap too short");
  a_ready_drop: assert property (!tx_stream_rst_n_i |=> !tx_ready_o) else $error("ready in reset");
  a_idle_reset: assert property (!tx_stream_rst_n_i [*4] |-> txc_o && txd_o == `XG_IDLE)
    else $error("not idle in stream reset");
  a_bad_last: assert property (rx_bad_o |-> rx_valid_o && rx_beat_o.last) else $error("bad flag off last");
  a_ready_wake: assert property ($fell(rst_i) && tx_stream_rst_n_i |=> tx_ready_o)
    else $error("ready not up after reset");
endmodule
bind ten_gig_mac_frame_tx_path ten_gig_mac_frame_tx_path_monitor mon_i (.clk_i(clk_i), .rst_i(rst_i),
  .tx_stream_rst_n_i(tx_stream_rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .tx_ready_o(tx_ready_o), .txd_o(txd_o), .txc_o(txc_o), .rx_beat_o(rx_beat_o), .rx_valid_o(rx_valid_o),
  .rx_bad_o(rx_bad_o));

// ===== testbench/test_ten_gig_mac_frame_tx_path.sv
// Purpose: frames through the transmit path against a queue model; bus and receive counts
// Assumes: one byte slot per clock on the wire
// Notes:   expected bytes come from a bench CRC, never from the design
`timescale 1ns/1ps
`include "mac_cfg.svh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module test_ten_gig_mac_frame_tx_path;
  logic clk_i = 1'b0, rst_i = 1'b1, tx_rst_n = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00, txd_o;
  logic [31:0] wb_dat = 32'h0, wb_dat_o, q, seed = 32'hd9e197f1;
  logic wb_ack_o, tx_valid, tx_ready_o, txc_o, rx_valid = 1'b0, rx_valid_o, rx_bad_o, err_seen = 1'b0;
  mac_pkg::beat_t tx_beat, rx_beat = 73'h0, rx_beat_o;
  logic [7:0] got[$];
  logic [15:0] lts [5] = '{16'h002e, 16'h05ff, `LT_TYPE_MIN, `LT_VLAN, `LT_PAUSE};
  int nds [5] = '{0, 45, 46, 100, 1600};
  int err_total = 0, num_checks = 0, done = 0, skip = 0, gcnt = 0, min_gap = 9999;
  int rx_bytes = 0, rx_frames = 0, rx_bad_n = 0;
  ten_gig_mac_frame_tx_path ten_gig_mac_frame_tx_path_i (.clk_i(clk_i), .rst_i(rst_i),
    .tx_stream_rst_n_i(tx_rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_beat_i(tx_beat),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready_o), .txd_o(txd_o), .txc_o(txc_o), .rx_beat_i(rx_beat),
    .rx_valid_i(rx_valid), .rx_beat_o(rx_beat_o), .rx_valid_o(rx_valid_o), .rx_bad_o(rx_bad_o));
  mac_tx_client mac_tx_client_i (.clk_i(clk_i), .tx_ready_i(tx_ready_o), .beat_o(tx_beat), .valid_o(tx_valid));
  always #2.5 clk_i = ~clk_i;
  // wire capture: frame bytes after start and preamble, gap length, error codes
  always @(posedge clk_i) begin
    if (txc_o === 1'b1 && txd_o === `XG_START) begin
      skip <= 7;
      if (gcnt < min_gap) min_gap <= gcnt;
    end else if (skip > 0) skip <= skip - 1;
    else if (txc_o === 1'b0) got.push_back(txd_o);
    gcnt <= (txc_o === 1'b1 && txd_o === `XG_TERM) ? 1 : gcnt + 1;
    if (txc_o === 1'b1 && txd_o === `XG_TERM) done <= done + 1;
    if (txc_o === 1'b1 && txd_o === `XG_ERROR) err_seen <= 1'b1;
    // receive side: delivered bytes, frame ends and bad marks
    if (rx_valid_o === 1'b1) rx_bytes <= rx_bytes + $countones(rx_beat_o.keep);
    if (rx_valid_o === 1'b1 && rx_beat_o.last === 1'b1) rx_frames <= rx_frames + 1;
    if (rx_bad_o === 1'b1) rx_bad_n <= rx_bad_n + 1;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // reflected crc, so the low byte of the result leaves first
  function automatic logic [31:0] crc(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (b[i]) begin
      c ^= {24'h0, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  // model: client bytes and expected wire bytes; pad only when the mac owns the fcs
  task automatic mk(input logic [15:0] lt, input int nd, input logic pass, output logic [7:0] cl[$], ex[$]);
    logic [31:0] c;
    cl = {};
    repeat (12) cl.push_back(8'(rnd()));
    cl.push_back(lt[15:8]);
    cl.push_back(lt[7:0]);
    repeat (nd) cl.push_back(8'(rnd()));
    ex = cl;
    if (!pass) while (ex.size() < 60) ex.push_back(8'h00);
    c = crc(ex);
    for (int i = 0; i < 4; i++) ex.push_back(c[8*i +: 8]);
    if (pass) cl = ex;
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_dat <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1); // without an ack only the watchdog ends this wait
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // nf frames back to back, then compare the wire and the transmit status
  task automatic run(input logic [15:0] lt, input int nd, input logic pass, input int nf);
    logic [7:0] cl[$], ex[$], all[$];
    int d0, k;
    all = {};
    got = {};
    min_gap = 9999;
    d0 = done;
    for (k = 0; k < nf; k++) begin
      mk(lt, nd + k, pass, cl, ex);
      all = {all, ex};
      mac_tx_client_i.send(cl, (k == 0) ? 2 : 0, k < nf - 1);
    end
    while (done < d0 + nf) @(posedge clk_i); // a hang is ended by the watchdog
    `CHK(got.size(), all.size())
    foreach (all[j]) `CHK(got[j], all[j])
    wb(1'b0, `REG_TX_STATUS, 32'h0, q);
    `CHK(q, {13'h0, lt == `LT_PAUSE, lt == `LT_VLAN, lt >= `LT_TYPE_MIN, lt})
  endtask
  task automatic rxf(input logic [7:0] b[$]);
    for (int n = 0; n < b.size(); n += 8) begin
      @(posedge clk_i);
      rx_valid <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        rx_beat.data[8*i +: 8] <= (n + i < b.size()) ? b[n + i] : 8'h5a;
        rx_beat.keep[i]        <= n + i < b.size();
      end
      rx_beat.last <= n + 8 >= b.size();
    end
    @(posedge clk_i);
    rx_valid <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    logic [7:0] cl[$], ex[$];
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `REG_CONFIG, 32'h0, q);
    `CHK(q, 32'h0)
    wb(1'b1, `REG_CONFIG, 32'hffffffff, q);
    wb(1'b0, `REG_CONFIG, 32'h0, q);
    `CHK(q, {16'h0, `CFG_WMASK})
    wb(1'b1, 8'h0c, 32'hffffffff, q);
    wb(1'b0, 8'h0c, 32'h0, q);
    `CHK(q, 32'h0)
    wb(1'b1, `REG_CONFIG, 32'h0, q);
    foreach (lts[i]) run(lts[i], nds[i], 1'b0, 1);
    run(16'h0800, 50, 1'b0, 3);
    `CHK(min_gap >= 12, 1'b1)
    wb(1'b1, `REG_CONFIG, 32'h00000002, q);
    // lengths step by one byte, so the deficit credit must shorten some gaps
    run(16'h0800, 50, 1'b0, 4);
    `CHK(min_gap >= 9, 1'b1)
    `CHK(min_gap < 12, 1'b1)
    wb(1'b1, `REG_CONFIG, 32'h00000804, q);
    run(16'h0800, 60, 1'b0, 2);
    `CHK(min_gap >= 32, 1'b1)
    wb(1'b1, `REG_CONFIG, 32'h00000001, q);
    run(16'h0800, 20, 1'b1, 1);
    run(16'h0040, 64, 1'b1, 1);
    wb(1'b1, `REG_CONFIG, 32'h0, q);
    mk(16'h0800, 50, 1'b0, cl, ex);
    rxf(ex);
    ex[20] ^= 8'h01;
    rxf(ex);
    wb(1'b0, `REG_RX_STATUS, 32'h0, q);
    `CHK(q, 32'h00010001)
    `CHK(rx_bad_n, 1)
    `CHK(rx_frames, 2)
    // length frames with checking on: short one loses its pad, long one lies about its size
    wb(1'b1, `REG_CONFIG, 32'h00000008, q);
    mk(16'h0010, 16, 1'b0, cl, ex);
    rxf(ex);
    mk(16'h0040, 60, 1'b0, cl, ex);
    rxf(ex);
    wb(1'b0, `REG_RX_STATUS, 32'h0, q);
    `CHK(q, 32'h00020002)
    `CHK(rx_bad_n, 2)
    `CHK(rx_frames, 4)
    `CHK(rx_bytes, 2 * (14 + 50) + (14 + 16) + (14 + 60))
    wb(1'b1, `REG_CONFIG, 32'h0, q);
    mk(16'h0800, 400, 1'b0, cl, ex);
    fork mac_tx_client_i.send(cl, 0, 1'b0); join_none
    repeat (30) @(posedge clk_i);
    tx_rst_n <= 1'b0;
    repeat (6) @(posedge clk_i);
    disable fork;
    mac_tx_client_i.drop();
    tx_rst_n <= 1'b1;
    `CHK(err_seen, 1'b1)
    run(16'h0800, 10, 1'b0, 1);
    close_out();
  end
  // watchdog: the whole sequence needs well under 20000 cycles
  initial begin
    repeat (80000) @(posedge clk_i);
    err_total++;
    close_out();
  end
endmodule
